// File: hdl/adcc_defines.svh
// Constants for the converter control block: offsets, bit positions, timing counts.
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

`define ADCC_ADDR_W 3
`define ADCC_ADDR_CTRL_A 3'h0
`define ADCC_ADDR_CTRL_B 3'h1
`define ADCC_ADDR_SELECT 3'h2
`define ADCC_ADDR_RES_LOW 3'h3
`define ADCC_ADDR_RES_HIGH 3'h4
`define ADCC_ADDR_POWER 3'h5

`define ADCC_A_EN 7
`define ADCC_A_START 6
`define ADCC_A_AUTO 5
`define ADCC_A_FLAG 4
`define ADCC_A_IRQEN 3
`define ADCC_A_PS_HI 2
`define ADCC_B_TS_HI 2
`define ADCC_S_REF 6
`define ADCC_S_LEFT 5
`define ADCC_S_CH_HI 3
`define ADCC_P_GATE 0

`define ADCC_CONV_NORMAL 5'h0d
`define ADCC_CONV_FIRST 5'h19
`define ADCC_SMP_NORMAL 5'h01
`define ADCC_SMP_FIRST 5'h0d
`define ADCC_CODE_BITS 5'h0a
`define ADCC_TRIAL_MSB 10'h200
`define ADCC_FREE_RUN_SRC 3'h0

`endif

// File: hdl/adcc_pkg.sv
// Types shared by the converter control modules.
package adcc_pkg;
	typedef enum logic [1:0] {SAR_IDLE, SAR_WAIT, SAR_RUN} adcc_sar_state_type;
	typedef logic [9:0] adcc_code_type;
endpackage : adcc_pkg

// File: hdl/adcc_conv_if.sv
// Signals between the control logic, the converter clock prescaler and the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface adcc_conv_if;
	logic en;
	logic [2:0] ps;
	logic restart;
	logic tick;
	logic start;
	logic first;
	logic comp;
	logic busy;
	logic done;
	logic sample;
	adcc_pkg::adcc_code_type dac;
	modport pre (input en, input ps, input restart, output tick);
	modport sar (input en, input tick, input start, input first, input comp,
		output busy, output done, output sample, output dac);
	modport ctl (output en, output ps, output restart, output start, output first,
		output comp, input tick, input busy, input done, input sample, input dac);
endinterface : adcc_conv_if
`default_nettype wire

// File: hdl/adcc_prescaler.sv
// Converter clock prescaler producing one tick per converter clock period.
`timescale 1ns/1ps
`default_nettype none
module adcc_prescaler (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control and tick
	adcc_conv_if.pre cv
);
	logic [7:0] cnt;
	wire [7:0] term = 8'((9'h002 << cv.ps) - 9'h001);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			cv.tick <= 1'b0;
		end else if (!cv.en || cv.restart) begin // [R23] [R14]
			cnt <= 8'h00;
			cv.tick <= 1'b0;
		end else begin
			cnt <= (cnt == term) ? 8'h00 : cnt + 8'h01;
			cv.tick <= (cnt == term);
		end
	end

	a_tick_needs_en: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
		!cv.en |=> !cv.tick) else $error("converter tick while disabled");
endmodule : adcc_prescaler
`default_nettype wire

// File: hdl/adcc_sar.sv
// Successive approximation sequencer timed by converter clock ticks.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_sar (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control and converter
	adcc_conv_if.sar cv
);
	adcc_pkg::adcc_sar_state_type state;
	logic [4:0] cnt;
	logic first_run;

	wire [4:0] smp = first_run ? `ADCC_SMP_FIRST : `ADCC_SMP_NORMAL;
	wire [4:0] last = (first_run ? `ADCC_CONV_FIRST : `ADCC_CONV_NORMAL) - 5'h01;
	wire in_bits = (cnt > smp) && (cnt <= smp + `ADCC_CODE_BITS);
	wire [3:0] bitpos = 4'(smp + `ADCC_CODE_BITS - cnt);
	wire [9:0] kept = cv.comp ? cv.dac : (cv.dac & ~(10'h001 << bitpos));
	wire [9:0] next_dac = (bitpos == 4'h0) ? kept : (kept | (10'h001 << (bitpos - 4'h1)));
	wire run_tick = (state == adcc_pkg::SAR_RUN) && cv.tick;
	wire finish = run_tick && (cnt == last);
	wire accept = cv.start && cv.en && ((state == adcc_pkg::SAR_IDLE) || finish);

	assign cv.busy = (state != adcc_pkg::SAR_IDLE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= adcc_pkg::SAR_IDLE;
			cnt <= 5'h00;
			first_run <= 1'b0;
			cv.dac <= 10'h000;
			cv.done <= 1'b0;
			cv.sample <= 1'b0;
		end else begin
			cv.done <= finish; // [R24]
			cv.sample <= run_tick && (cnt == smp);
			if (!cv.en) begin
				state <= adcc_pkg::SAR_IDLE;
			end else if (accept) begin
				state <= adcc_pkg::SAR_WAIT;
				first_run <= cv.first; // [R22]
			end else if (finish) begin
				state <= adcc_pkg::SAR_IDLE;
			end else if (state == adcc_pkg::SAR_WAIT && cv.tick) begin
				state <= adcc_pkg::SAR_RUN;
				cnt <= 5'h00;
			end else if (run_tick) begin
				cnt <= cnt + 5'h01;
			end
			if (run_tick && cnt == smp) begin
				cv.dac <= `ADCC_TRIAL_MSB;
			end else if (run_tick && in_bits) begin
				cv.dac <= next_dac; // [R1]
			end
		end
	end

	a_conv_length: assert property (@(posedge clk) disable iff (!rst_n) // [R22]
		state == adcc_pkg::SAR_RUN |-> cnt <= last) else $error("conversion ran past its length");
endmodule : adcc_sar
`default_nettype wire

// File: hdl/adcc_top.sv
// Conversion control for a successive approximation converter with software registers.
//
// Notes on behaviour
// (R1) Ten-bit code, zero ground, ones reference.
// (R2) One bit picks supply or internal reference.
// (R3) Channel field routes pin, ground or bandgap.
// (R4) Nine-way input multiplexer including temperature sensor.
// (R5) Selections take effect only while enabled.
// (R6) Right-justified result, left when left_align set.
// (R7) Software reads low byte before high.
// (R8) Low byte read blocks all result updates.
// (R9) High byte read removes the block.
// (R10) Every completion raises the done request.
// (R11) Start bit begins conversion, clears at end.
// (R12) Channel writes wait for conversion end.
// (R13) Auto trigger enable uses selected source.
// (R14) Trigger rising edge resets prescaler, starts.
// (R15) Only fresh rising edges start conversions.
// (R16) Edges during a conversion are ignored.
// (R17) Trigger flags need clearing between events.
// (R18) Done-flag source gives continuous conversion.
// (R19) Start bit reads one during any conversion.
// (R20) Software clears power gate before use.
// (R21) Software disables converter before deep sleep.
// (R22) Conversions take 13 ticks, first 25.
// (R23) Prescaler runs only while enabled.
// (R24) Completion writes result, sets flag, clears start.
// (R25) Left mode: bits nine..two high, rest low.
// (R26) Free-running source code is a parameter.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_top #(
	parameter logic [2:0] FREE_RUN_SRC = `ADCC_FREE_RUN_SRC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [`ADCC_ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Trigger sources
	input wire logic [7:0] TRIG_IN,
	// Analog front end
	input wire logic COMP_IN,
	output logic [3:0] CH_SEL,
	output logic REF_SEL,
	output logic ANALOG_EN,
	output logic SAMPLE,
	output logic [9:0] DAC_CODE,
	// Conversion complete request
	output logic CONV_IRQ
);
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	adcc_conv_if cv ();

	adcc_prescaler u_pre (
		.clk(CLK),
		.rst_n(rst_n),
		.cv(cv.pre)
	);

	adcc_sar u_sar (
		.clk(CLK),
		.rst_n(rst_n),
		.cv(cv.sar)
	);

	// Software-visible state, plus the internal lock, first-conversion marker and trigger history.
	logic enable;
	logic start_bit;
	logic auto_trig_enable;
	logic conv_done_flag;
	logic irq_enable;
	logic [2:0] prescale;
	logic [2:0] trig_source_sel;
	logic ref_select;
	logic left_align;
	logic [3:0] channel_select;
	logic adc_power_gate_bit;
	adcc_pkg::adcc_code_type result;
	logic locked;
	logic first_pending;
	logic trig_prev;

	// Places the code into the high or low byte for either alignment.
	function automatic logic [7:0] place(input adcc_pkg::adcc_code_type code,
		input logic left, input logic high);
		logic [7:0] b;
		if (left) begin
			b = high ? code[9:2] : {code[1:0], 6'h00}; // [R25]
		end else begin
			b = high ? {6'h00, code[9:8]} : code[7:0]; // [R6]
		end
		return b;
	endfunction : place

	// Register decode.
	wire wr_a = WR && (ADDR == `ADCC_ADDR_CTRL_A);
	wire wr_b = WR && (ADDR == `ADCC_ADDR_CTRL_B);
	wire wr_s = WR && (ADDR == `ADCC_ADDR_SELECT);
	wire wr_p = WR && (ADDR == `ADCC_ADDR_POWER);
	wire rd_low = RD && (ADDR == `ADCC_ADDR_RES_LOW);
	wire rd_high = RD && (ADDR == `ADCC_ADDR_RES_HIGH);

	// The power gate overrides enable so a gated converter never runs.
	wire run_en = enable && !adc_power_gate_bit;
	wire busy = cv.busy;
	wire done = cv.done;

	// Trigger selection and edge detection.
	wire free_run = auto_trig_enable && (trig_source_sel == FREE_RUN_SRC); // [R26]
	wire trig_level = TRIG_IN[trig_source_sel]; // [R13]
	wire trig_edge = trig_level && !trig_prev; // [R15]
	wire trig_go = run_en && auto_trig_enable && !free_run && trig_edge && !busy; // [R16]
	wire sw_go = run_en && wr_a && WDATA[`ADCC_A_START] && !busy; // [R11] [R19]
	wire free_go = run_en && free_run && done; // [R18]
	wire start_req = trig_go || sw_go || free_go;

	assign cv.en = run_en;
	assign cv.ps = prescale;
	assign cv.restart = trig_go; // [R14]
	assign cv.start = start_req;
	assign cv.first = first_pending; // [R22]
	assign cv.comp = COMP_IN;

	// Selections follow software only while enabled and idle, or at the end of a conversion.
	wire sel_open = run_en && (!busy || done); // [R5] [R12]

	wire [7:0] ctrl_a_val = {enable, start_bit, auto_trig_enable, conv_done_flag,
		irq_enable, prescale};
	wire [7:0] select_val = {1'b0, ref_select, left_align, 1'b0, channel_select};
	wire [7:0] next_rdata =
		(ADDR == `ADCC_ADDR_CTRL_A) ? ctrl_a_val :
		(ADDR == `ADCC_ADDR_CTRL_B) ? {5'h00, trig_source_sel} :
		(ADDR == `ADCC_ADDR_SELECT) ? select_val :
		(ADDR == `ADCC_ADDR_RES_LOW) ? place(result, left_align, 1'b0) :
		(ADDR == `ADCC_ADDR_RES_HIGH) ? place(result, left_align, 1'b1) :
		(ADDR == `ADCC_ADDR_POWER) ? {7'h00, adc_power_gate_bit} : 8'h00;

	// Control register A.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			enable <= 1'b0;
			auto_trig_enable <= 1'b0;
			irq_enable <= 1'b0;
			prescale <= 3'h0;
		end else if (wr_a) begin
			enable <= WDATA[`ADCC_A_EN];
			auto_trig_enable <= WDATA[`ADCC_A_AUTO];
			irq_enable <= WDATA[`ADCC_A_IRQEN];
			prescale <= WDATA[`ADCC_A_PS_HI:0];
		end
	end

	// Other writable registers.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			trig_source_sel <= 3'h0;
			adc_power_gate_bit <= 1'b0;
		end else begin
			if (wr_b) begin
				trig_source_sel <= WDATA[`ADCC_B_TS_HI:0];
			end
			if (wr_p) begin
				adc_power_gate_bit <= WDATA[`ADCC_P_GATE];
			end
		end
	end

	// Temporary selection register, written at any time.
	logic tmp_ref;
	logic [3:0] tmp_ch;
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tmp_ref <= 1'b0;
			tmp_ch <= 4'h0;
			left_align <= 1'b0;
		end else if (wr_s) begin
			tmp_ref <= WDATA[`ADCC_S_REF];
			tmp_ch <= WDATA[`ADCC_S_CH_HI:0];
			left_align <= WDATA[`ADCC_S_LEFT];
		end
	end
	assign ref_select = tmp_ref;
	assign channel_select = tmp_ch;

	// Applied selection seen by the analog side.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			CH_SEL <= 4'h0;
			REF_SEL <= 1'b0;
		end else if (sel_open) begin
			CH_SEL <= tmp_ch; // [R3] [R4]
			REF_SEL <= tmp_ref; // [R2]
		end
	end

	// Start bit: set by any start, held for the conversion, cleared at completion.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			start_bit <= 1'b0;
		end else if (start_req) begin
			start_bit <= 1'b1; // [R19]
		end else if (done || !run_en) begin
			start_bit <= 1'b0; // [R11] [R24]
		end
	end

	// Done flag: completion wins over a write-one clear in the same cycle.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			conv_done_flag <= 1'b0;
		end else if (done) begin
			conv_done_flag <= 1'b1; // [R10] [R17]
		end else if (wr_a && WDATA[`ADCC_A_FLAG]) begin
			conv_done_flag <= 1'b0;
		end
	end

	// Result and its lock between the two byte reads.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			result <= 10'h000;
			locked <= 1'b0;
		end else begin
			// A completion in the cycle of a low-byte read is dropped, so both bytes agree.
			if (done && !locked && !rd_low) begin
				result <= cv.dac; // [R8] [R24]
			end
			if (rd_high) begin
				locked <= 1'b0; // [R9]
			end else if (rd_low) begin
				locked <= 1'b1; // [R8]
			end
		end
	end

	// First-conversion marker and trigger history.
	// The history follows the selected source, so moving to a source that is already high
	// counts as an edge; software should change the source while auto triggering is off.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			first_pending <= 1'b1;
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= trig_level;
			if (!run_en) begin
				first_pending <= 1'b1;
			end else if (start_req) begin
				first_pending <= 1'b0; // [R22]
			end
		end
	end

	// Registered outputs.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			RDATA <= 8'h00;
			ANALOG_EN <= 1'b0;
			SAMPLE <= 1'b0;
			DAC_CODE <= 10'h000;
			CONV_IRQ <= 1'b0;
		end else begin
			RDATA <= RD ? next_rdata : 8'h00;
			ANALOG_EN <= run_en;
			SAMPLE <= cv.sample;
			DAC_CODE <= cv.dac;
			CONV_IRQ <= (conv_done_flag || done) && irq_enable; // [R10]
		end
	end

	default clocking dc @(posedge CLK); endclocking
	default disable iff (!rst_n);

	sequence s_trig_edge_idle;
		run_en && auto_trig_enable && !free_run && trig_edge && !busy;
	endsequence
	sequence s_waiting;
		busy && start_bit;
	endsequence

	sequence s_low_read;
		rd_low && !rd_high;
	endsequence
	sequence s_result_blocked;
		locked && $stable(result);
	endsequence

	a_trig_starts: assert property (s_trig_edge_idle |=> s_waiting) // [R14]
		else $error("trigger edge did not start a conversion");
	a_trig_ignored_busy: assert property (busy && !done |-> !cv.restart && !cv.start) // [R16]
		else $error("trigger accepted during conversion");
	a_start_reads_busy: assert property (busy |-> start_bit) // [R19]
		else $error("start bit low during conversion");
	a_done_sets_flag: assert property (done |=> conv_done_flag) // [R10]
		else $error("completion did not set the flag");
	a_done_clears_start: assert property (done && !start_req |=> !start_bit) // [R24]
		else $error("start bit not cleared at completion");
	a_lock_holds_result: assert property (locked && !rd_high |=> $stable(result)) // [R8]
		else $error("result changed while blocked");
	a_high_unlocks: assert property (rd_high |=> !locked) // [R9]
		else $error("high byte read did not unblock");
	a_sel_stable_busy: assert property (busy && $past(busy) && !$past(done) |-> $stable(CH_SEL)) // [R12]
		else $error("channel changed during conversion");
	a_free_run_restart: assert property (free_go |=> busy) // [R18]
		else $error("free running did not restart");
	a_left_high_byte: assert property (RD && ADDR == `ADCC_ADDR_RES_HIGH && left_align // [R25]
		|=> RDATA == $past(result[9:2]))
		else $error("left aligned high byte wrong");
	a_right_low_byte: assert property (RD && ADDR == `ADCC_ADDR_RES_LOW && !left_align // [R6]
		|=> RDATA == $past(result[7:0]))
		else $error("right aligned low byte wrong");
	a_low_locks: assert property (s_low_read |=> s_result_blocked) // [R8]
		else $error("low byte read did not block the result");
	a_discard_raises_irq: assert property (done && locked && irq_enable |=> CONV_IRQ) // [R10]
		else $error("discarded result raised no request");
	a_sw_start_runs: assert property (sw_go |=> s_waiting) // [R11]
		else $error("start write did not begin a conversion");
	a_level_no_restart: assert property (trig_prev && trig_level |-> !cv.restart) // [R15]
		else $error("held trigger level restarted the prescaler");
	a_free_start_held: assert property (free_go |=> start_bit) // [R18]
		else $error("start bit dropped between free running conversions");
	a_sel_held_off: assert property (!$past(run_en) // [R5]
		|-> $stable(CH_SEL) && $stable(REF_SEL))
		else $error("selection applied while disabled");
	a_analog_off: assert property (!run_en |=> !ANALOG_EN) // [R23]
		else $error("analog side powered while disabled");
endmodule : adcc_top
`default_nettype wire

// File: sim/adcc_top_tb.sv
// Self-checking bench for the converter control block, driven through its register port.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb;
	localparam int TK = 4;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [2:0] ADDR = 3'h0;
	logic [7:0] WDATA = 8'h00;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [7:0] TRIG_IN = 8'h00;
	logic COMP_IN = 1'b0;
	logic [7:0] RDATA;
	logic [3:0] CH_SEL;
	logic REF_SEL;
	logic ANALOG_EN;
	logic SAMPLE;
	logic [9:0] DAC_CODE;
	logic CONV_IRQ;
	logic [9:0] target = 10'h000;
	logic [7:0] d;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	int samples = 0;
	int t0 = 0;
	int s0 = 0;

	adcc_top #(.FREE_RUN_SRC(3'h0)) dut (
		.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .TRIG_IN(TRIG_IN), .COMP_IN(COMP_IN), .CH_SEL(CH_SEL),
		.REF_SEL(REF_SEL), .ANALOG_EN(ANALOG_EN), .SAMPLE(SAMPLE), .DAC_CODE(DAC_CODE),
		.CONV_IRQ(CONV_IRQ)
	);

	always #5 CLK = ~CLK;

	// The comparator lags the trial code by one cycle, which a tick period of four hides.
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		COMP_IN <= (target >= DAC_CODE);
		if (SAMPLE === 1'b1) begin
			samples <= samples + 1;
		end
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask : rd

	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Clears the done flag first so that the request line shows the new completion.
	task automatic start_conv(input logic [7:0] a);
		wr(3'h0, (a & 8'hbf) | 8'h10);
		wr(3'h0, a);
		t0 = cyc;
	endtask : start_conv

	task automatic wait_done(input int n);
		int k;
		k = 0;
		while (CONV_IRQ !== 1'b1 && k < 400) begin
			@(posedge CLK);
			k++;
		end
		chk("conversion time", 10'h1, 10'((cyc - t0 >= n * TK) && (cyc - t0 <= (n + 1) * TK + 6)));
	endtask : wait_done

	task automatic rd_chk(input logic [2:0] a, input string nm, input logic [7:0] e);
		rd(a);
		chk(nm, 10'(e), 10'(d));
	endtask : rd_chk

	task automatic results();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge CLK);
		mismatches++;
		$display("watchdog expired");
		results();
	end

	initial begin
		repeat (20) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK);
		rd_chk(3'h0, "ctrl_a reset", 8'h00);
		wr(3'h2, 8'h43);
		repeat (3) @(posedge CLK);
		chk("channel while disabled", 10'h0, 10'({REF_SEL, CH_SEL}));
		wr(3'h5, 8'h01);
		wr(3'h0, 8'h89);
		repeat (3) @(posedge CLK);
		chk("analog enable gated", 10'h0, 10'(ANALOG_EN));
		wr(3'h5, 8'h00);
		repeat (3) @(posedge CLK);
		chk("analog enable", 10'h1, 10'(ANALOG_EN));
		chk("applied selection", 10'h13, 10'({REF_SEL, CH_SEL}));
		target = 10'h2c5;
		start_conv(8'hc9);
		rd_chk(3'h0, "start bit busy", 8'hc9);
		wait_done(25);
		chk("final trial code", 10'h2c5, DAC_CODE);
		rd(3'h0);
		chk("start and flag at end", 10'h1, 10'({d[6], d[4]}));
		rd_chk(3'h3, "low right", 8'hc5);
		rd_chk(3'h4, "high right", 8'h02);
		target = 10'h3ff;
		start_conv(8'hc9);
		wait_done(13);
		rd_chk(3'h3, "low full scale", 8'hff);
		rd_chk(3'h4, "high full scale", 8'h03);
		wr(3'h2, 8'h63);
		target = 10'h2c5;
		start_conv(8'hc9);
		wait_done(13);
		rd_chk(3'h3, "low left", 8'h40);
		rd_chk(3'h4, "high left", 8'hb1);
		target = 10'h156;
		rd_chk(3'h3, "low before lock", 8'h40);
		start_conv(8'hc9);
		wait_done(13);
		rd_chk(3'h4, "high kept locked", 8'hb1);
		rd_chk(3'h3, "low kept locked", 8'h40);
		rd_chk(3'h4, "high unlock", 8'hb1);
		start_conv(8'hc9);
		wait_done(13);
		rd_chk(3'h3, "low after unlock", 8'h80);
		rd_chk(3'h4, "high after unlock", 8'h55);
		start_conv(8'hc9);
		wr(3'h2, 8'h25);
		repeat (3) @(posedge CLK);
		chk("channel held in conversion", 10'h13, 10'({REF_SEL, CH_SEL}));
		wait_done(13);
		repeat (3) @(posedge CLK);
		chk("channel after conversion", 10'h05, 10'({REF_SEL, CH_SEL}));
		wr(3'h1, 8'h02);
		wr(3'h0, 8'hb9);
		s0 = samples;
		@(posedge CLK);
		TRIG_IN[2] <= 1'b1;
		t0 = cyc;
		repeat (4 * TK) @(posedge CLK);
		rd(3'h0);
		chk("start bit on trigger", 10'h1, 10'(d[6]));
		@(posedge CLK);
		TRIG_IN[2] <= 1'b0;
		@(posedge CLK);
		TRIG_IN[2] <= 1'b1;
		wait_done(13);
		@(posedge CLK);
		TRIG_IN[5] <= 1'b1;
		repeat (30 * TK) @(posedge CLK);
		chk("one conversion per edge", 10'h1, 10'(samples - s0));
		rd(3'h0);
		chk("no retrigger on level", 10'h0, 10'(d[6]));
		wr(3'h0, 8'hb9);
		@(posedge CLK);
		TRIG_IN[2] <= 1'b0;
		@(posedge CLK);
		TRIG_IN[2] <= 1'b1;
		t0 = cyc;
		wait_done(13);
		chk("fresh edge converts", 10'h2, 10'(samples - s0));
		start_conv(8'hf9);
		wait_done(13);
		wr(3'h1, 8'h00);
		s0 = samples;
		start_conv(8'he9);
		repeat (60 * TK) @(posedge CLK);
		chk("free running count", 10'h1, 10'(samples - s0 >= 3));
		rd(3'h0);
		chk("start bit free running", 10'h1, 10'(d[6]));
		wr(3'h0, 8'h89);
		repeat (20 * TK) @(posedge CLK);
		s0 = samples;
		repeat (20 * TK) @(posedge CLK);
		chk("free running stops", 10'h0, 10'(samples - s0));
		wr(3'h0, 8'h00);
		repeat (3) @(posedge CLK);
		chk("analog disabled", 10'h0, 10'(ANALOG_EN));
		rd_chk(3'h6, "unmapped 6", 8'h00);
		rd_chk(3'h7, "unmapped 7", 8'h00);
		@(posedge CLK);
		#1 chk("read data idle", 10'h0, 10'(RDATA));
		results();
	end
endmodule : adcc_top_tb
`default_nettype wire
